// ### include/maxu_consts.svh
// Constants for the address-fault exception unit.
// Assumes inclusion by bare name from the core, the assertions and the test.
`ifndef MAXU_CONSTS_SVH
`define MAXU_CONSTS_SVH
// Register byte offsets on APB
`define MAXU_OFS_FAULT 8'h00
`define MAXU_OFS_PAGE 8'h04
`define MAXU_OFS_CODE 8'h08
`define MAXU_OFS_VBASE 8'h0c
`define MAXU_OFS_STAT 8'h10
`define MAXU_OFS_SAVPC 8'h14
`define MAXU_OFS_SSTAT 8'h18
`define MAXU_OFS_SSTK 8'h1c
// Status register fields
`define MAXU_ST_PRIV 30
`define MAXU_ST_BANK 29
`define MAXU_ST_BLOCK 28
`define MAXU_ST_FPUOFF 15
`define MAXU_ST_MASK_HI 7
`define MAXU_ST_MASK_LO 4
`define MAXU_MASK_ALL 4'hf
`define MAXU_ST_RST 32'h700000f0
// Page entry high fields
`define MAXU_PAGE_HI 31
`define MAXU_PAGE_LO 10
// Exception codes
`define MAXU_EC_POR 12'h000
`define MAXU_EC_MRST 12'h020
`define MAXU_EC_MISS_RD 12'h040
`define MAXU_EC_MISS_WR 12'h060
`define MAXU_EC_IPW 12'h080
`define MAXU_EC_PROT_RD 12'h0a0
`define MAXU_EC_PROT_WR 12'h0c0
`define MAXU_EC_ADE_RD 12'h0e0
`define MAXU_EC_ADE_WR 12'h100
`define MAXU_EC_MULTI 12'h140
// Branch targets
`define MAXU_RESET_PC 32'ha0000000
`define MAXU_VOFS_MISS 32'h00000400
`define MAXU_VOFS_GEN 32'h00000100
`define MAXU_VBASE_RST 32'h00000000
`endif

// ### include/maxu_pkg.sv
// Types shared by the address-fault exception unit and its bench.
// Assumes maxu_consts.svh on the include path.
package maxu_pkg;
    typedef enum logic [1:0] {
        MAXU_SZ_BYTE = 2'h0,
        MAXU_SZ_WORD = 2'h1,
        MAXU_SZ_LONG = 2'h2,
        MAXU_SZ_QUAD = 2'h3
    } maxu_size_t;

    // Instruction-fetch lookup result for one instruction
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic multi_hit;
        logic miss;
        logic prot;
    } maxu_fetch_t;

    // Operand lookup result for the same instruction
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic write;
        maxu_size_t size;
        logic multi_hit;
        logic miss;
        logic dirty;
        logic [1:0] prot;
    } maxu_opnd_t;

    // Architectural context of the instruction
    typedef struct packed {
        logic [31:0] pc;
        logic [31:0] r15;
    } maxu_ctx_t;
endpackage : maxu_pkg

// ### core/maxu_core.sv
// Address-fault exception entry: translation and alignment faults.
// Assumes the pipeline presents at most one instruction per cycle, in
// program order, with its fetch and operand lookup results attached.
//
// Behaviour
// - Fetch multi-hit writes code 140 and branches to the reset address.
// - Operand multi-hit writes code 140 and branches to the reset address.
// - Multi-hit zeroes vector base, sets privilege, bank, block and mask bits, clears FPU-off.
// - Multi-hit requests manual-reset initialisation of core and peripherals.
// - Every fault loads fault address and page number; identifier kept.
// - General exceptions save pc, status and register 15.
// - General exception entry sets block, privilege and bank bits.
// - Operand miss writes 040 read or 060 write, vectors base plus 400.
// - Fetch miss writes 040 and vectors base plus 400.
// - Store hitting a clean page writes 080, vectors base plus 100.
// - Operand protection per two-bit field; user under 00 or 01 faults.
// - Operand protection fault writes 0a0 read or 0c0 write, base plus 100.
// - Fetch protection bit 0 is privileged only; fault writes 0a0.
// - Odd address on word access is a data address error.
// - Misaligned longword or quadword access is a data address error.
// - User access to the upper half is a data address error.
// - Data address error writes 0e0 read or 100 write, base plus 100.
// - General exception while blocked takes the manual-reset path instead.
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "maxu_consts.svh"

module maxu_core
    import maxu_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pipeline side
    input wire maxu_fetch_t fetch_in,
    input wire maxu_opnd_t opnd_in,
    input wire maxu_ctx_t ctx_in,
    // Exception entry
    output logic exc_take,
    output logic [31:0] exc_target,
    output logic mreset_req,
    output logic [31:0] status_out
);

    if (ADDR_W != 32) begin : g_width_check
        $error("maxu_core serves 32-bit addresses only");
    end

    // ------------------------------------------------------------
    // Architectural registers
    // ------------------------------------------------------------
    logic [31:0] fault_address_reg;
    logic [31:0] page_entry_high_reg;
    logic [31:0] exception_code_reg;
    logic [31:0] vector_base_reg;
    logic [31:0] status_reg;
    logic [31:0] saved_pc_reg;
    logic [31:0] saved_status_reg;
    logic [31:0] saved_stack_reg;
    logic [31:0] prdata_r;
    logic exc_take_r;
    logic [31:0] exc_target_r;
    logic mreset_r;

    // ------------------------------------------------------------
    // Fault detection
    // ------------------------------------------------------------
    wire user_mode = ~status_reg[`MAXU_ST_PRIV];
    wire blocked = status_reg[`MAXU_ST_BLOCK];
    wire fv = fetch_in.valid;
    wire ov = opnd_in.valid;

    wire f_multi = fv & fetch_in.multi_hit;
    wire f_miss = fv & ~fetch_in.multi_hit & fetch_in.miss;
    wire f_prot = fv & ~fetch_in.multi_hit & ~fetch_in.miss
        & user_mode & ~fetch_in.prot;
    wire f_fault = f_multi | f_miss | f_prot;

    // Alignment per access size
    wire [2:0] oa = opnd_in.addr[2:0];
    wire mis_word = (opnd_in.size == MAXU_SZ_WORD) & oa[0];
    wire mis_long = (opnd_in.size == MAXU_SZ_LONG)
        & (oa[1:0] != 2'h0);
    wire mis_quad = (opnd_in.size == MAXU_SZ_QUAD)
        & (oa != 3'h0);
    wire user_hi = user_mode & opnd_in.addr[31];
    wire o_ade = ov & (mis_word | mis_long | mis_quad | user_hi);

    // Address errors are found before the lookup, so they win
    wire o_multi = ov & ~o_ade & opnd_in.multi_hit;
    wire o_look = ov & ~o_ade & ~opnd_in.multi_hit;
    wire o_miss = o_look & opnd_in.miss;
    wire o_hit = o_look & ~opnd_in.miss;

    // User under 00/01 is denied; writes need bit 0 set
    wire perm_user_ok = opnd_in.prot[1];
    wire perm_wr_ok = opnd_in.prot[0];
    wire prot_bad = (user_mode & ~perm_user_ok)
        | (opnd_in.write & ~perm_wr_ok);
    wire o_prot = o_hit & prot_bad;
    wire o_ipw = o_hit & ~prot_bad & opnd_in.write
        & ~opnd_in.dirty;

    // Fetch faults belong to an earlier stage than the operand access
    wire o_fault = ~f_fault
        & (o_ade | o_multi | o_miss | o_prot | o_ipw);
    wire any_fault = f_fault | o_fault;
    wire is_multi = f_multi | (o_fault & o_multi);
    wire is_general = any_fault & ~is_multi;
    wire to_mreset = is_general & blocked;
    wire to_reset = is_multi | to_mreset;
    wire save_ctx = is_general & ~blocked;

    wire [31:0] fault_addr = f_fault ? fetch_in.addr : opnd_in.addr;
    wire wr = opnd_in.write;

    // ------------------------------------------------------------
    // Code and target selection
    // ------------------------------------------------------------
    wire [11:0] code_fetch = f_miss ? `MAXU_EC_MISS_RD
        : `MAXU_EC_PROT_RD;
    wire [11:0] code_ade = wr ? `MAXU_EC_ADE_WR
        : `MAXU_EC_ADE_RD;
    wire [11:0] code_miss = wr ? `MAXU_EC_MISS_WR
        : `MAXU_EC_MISS_RD;
    wire [11:0] code_prot = wr ? `MAXU_EC_PROT_WR
        : `MAXU_EC_PROT_RD;
    wire [11:0] code_opnd = o_ade ? code_ade
        : o_miss ? code_miss
        : o_prot ? code_prot
        : `MAXU_EC_IPW;
    wire [11:0] code_gen = f_fault ? code_fetch : code_opnd;
    wire [11:0] code_sel = is_multi ? `MAXU_EC_MULTI
        : to_mreset ? `MAXU_EC_MRST
        : code_gen;

    wire use_miss_vec = f_miss | (o_fault & o_miss);
    wire [31:0] vofs = use_miss_vec ? `MAXU_VOFS_MISS
        : `MAXU_VOFS_GEN;
    wire [31:0] target_sel = to_reset ? `MAXU_RESET_PC
        : vector_base_reg + vofs;

    // Status image after a reset-like entry
    logic [31:0] st_init;
    always_comb begin
        st_init = status_reg;
        st_init[`MAXU_ST_PRIV] = 1'b1;
        st_init[`MAXU_ST_BANK] = 1'b1;
        st_init[`MAXU_ST_BLOCK] = 1'b1;
        st_init[`MAXU_ST_FPUOFF] = 1'b0;
        st_init[`MAXU_ST_MASK_HI:`MAXU_ST_MASK_LO] = `MAXU_MASK_ALL;
    end

    // Status image after a general entry
    logic [31:0] st_gen;
    always_comb begin
        st_gen = status_reg;
        st_gen[`MAXU_ST_PRIV] = 1'b1;
        st_gen[`MAXU_ST_BANK] = 1'b1;
        st_gen[`MAXU_ST_BLOCK] = 1'b1;
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire setup = psel & ~penable;
    wire wr_en = psel & penable & pwrite;
    wire a_fault = paddr == `MAXU_OFS_FAULT;
    wire a_page = paddr == `MAXU_OFS_PAGE;
    wire a_code = paddr == `MAXU_OFS_CODE;
    wire a_vbase = paddr == `MAXU_OFS_VBASE;
    wire a_stat = paddr == `MAXU_OFS_STAT;
    wire a_savpc = paddr == `MAXU_OFS_SAVPC;
    wire a_sstat = paddr == `MAXU_OFS_SSTAT;
    wire a_sstk = paddr == `MAXU_OFS_SSTK;
    wire mapped = a_fault | a_page | a_code | a_vbase | a_stat
        | a_savpc | a_sstat | a_sstk;

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    wire [31:0] rd_mux = a_fault ? fault_address_reg
        : a_page ? page_entry_high_reg
        : a_code ? exception_code_reg
        : a_vbase ? vector_base_reg
        : a_stat ? status_reg
        : a_savpc ? saved_pc_reg
        : a_sstat ? saved_status_reg
        : a_sstk ? saved_stack_reg
        : 32'h00000000;

    // ------------------------------------------------------------
    // Next-state values; a fault entry wins over a software write
    // ------------------------------------------------------------
    wire [31:0] page_fault_img = {fault_addr[`MAXU_PAGE_HI:`MAXU_PAGE_LO],
        page_entry_high_reg[`MAXU_PAGE_LO-1:0]};

    wire [31:0] fault_nxt = any_fault ? fault_addr
        : (wr_en & a_fault) ? pwdata : fault_address_reg;
    wire [31:0] page_nxt = any_fault ? page_fault_img
        : (wr_en & a_page) ? pwdata : page_entry_high_reg;
    wire [31:0] code_nxt = any_fault ? {20'h00000, code_sel}
        : (wr_en & a_code) ? pwdata : exception_code_reg;
    wire [31:0] vbase_nxt = to_reset ? `MAXU_VBASE_RST
        : (wr_en & a_vbase) ? pwdata : vector_base_reg;
    wire [31:0] stat_nxt = to_reset ? st_init
        : save_ctx ? st_gen
        : (wr_en & a_stat) ? pwdata : status_reg;
    wire [31:0] savpc_nxt = save_ctx ? ctx_in.pc
        : (wr_en & a_savpc) ? pwdata : saved_pc_reg;
    wire [31:0] sstat_nxt = save_ctx ? status_reg
        : (wr_en & a_sstat) ? pwdata : saved_status_reg;
    wire [31:0] sstk_nxt = save_ctx ? ctx_in.r15
        : (wr_en & a_sstk) ? pwdata : saved_stack_reg;
    wire [31:0] prdata_nxt = setup ? rd_mux : prdata_r;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_address_reg <= 32'h00000000;
            page_entry_high_reg <= 32'h00000000;
            exception_code_reg <= {20'h00000, `MAXU_EC_POR};
            vector_base_reg <= `MAXU_VBASE_RST;
            status_reg <= `MAXU_ST_RST;
        end else begin
            fault_address_reg <= fault_nxt;
            page_entry_high_reg <= page_nxt;
            exception_code_reg <= code_nxt;
            vector_base_reg <= vbase_nxt;
            status_reg <= stat_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            saved_pc_reg <= 32'h00000000;
            saved_status_reg <= 32'h00000000;
            saved_stack_reg <= 32'h00000000;
            prdata_r <= 32'h00000000;
        end else begin
            saved_pc_reg <= savpc_nxt;
            saved_status_reg <= sstat_nxt;
            saved_stack_reg <= sstk_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // Entry strobe and target are registered, one cycle after the fault
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exc_take_r <= 1'b0;
            exc_target_r <= `MAXU_RESET_PC;
            mreset_r <= 1'b0;
        end else begin
            exc_take_r <= any_fault;
            exc_target_r <= any_fault ? target_sel : exc_target_r;
            mreset_r <= to_reset;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = prdata_r;
    assign exc_take = exc_take_r;
    assign exc_target = exc_target_r;
    assign mreset_req = mreset_r;
    assign status_out = status_reg;

endmodule : maxu_core
`default_nettype wire

// ### bench/maxu_assertions.sv
// Checks on the exception entry outputs of maxu_core.
// Assumes one pclk domain and a vector base kept 4 KB aligned.
`timescale 1ns/100ps
`default_nettype none
`include "maxu_consts.svh"
module maxu_assertions
    import maxu_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pipeline side and entry
    input wire maxu_fetch_t fetch_in,
    input wire maxu_opnd_t opnd_in,
    input wire logic exc_take,
    input wire logic [31:0] exc_target,
    input wire logic mreset_req,
    input wire logic [31:0] status_out
);
    wire logic user = !status_out[`MAXU_ST_PRIV];
    wire logic blk = status_out[`MAXU_ST_BLOCK];
    wire logic fv = fetch_in.valid;
    wire logic ov = opnd_in.valid;
    wire logic [2:0] oa = opnd_in.addr[2:0];
    wire logic f_any = fv && (fetch_in.multi_hit || fetch_in.miss ||
        (user && !fetch_in.prot));
    wire logic f_gen = fv && !fetch_in.multi_hit && fetch_in.miss;
    wire logic o_odd = ov && opnd_in.size == MAXU_SZ_WORD && oa[0];
    wire logic o_long = ov && opnd_in.size == MAXU_SZ_LONG && oa[1:0] != 0;
    wire logic o_quad = ov && opnd_in.size == MAXU_SZ_QUAD && oa != 3'h0;
    wire logic o_hi = ov && user && opnd_in.addr[31];
    wire logic o_ae = o_odd || o_long || o_quad || o_hi;
    // Only an otherwise clean instruction isolates each cause
    wire logic gen_ok = !f_any && !blk;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    fetch_multi_a: assert property (fv && fetch_in.multi_hit |=>
        exc_take && mreset_req && exc_target == `MAXU_RESET_PC)
        else $error("fetch multi-hit did not take reset path");
    opnd_multi_a: assert property (ov && opnd_in.multi_hit && !o_ae &&
        !f_any |=> mreset_req && exc_target == `MAXU_RESET_PC)
        else $error("operand multi-hit did not take reset path");
    multi_init_a: assert property (mreset_req |->
        status_out[30:28] == 3'h7 && !status_out[`MAXU_ST_FPUOFF] &&
        status_out[7:4] == 4'hf) else $error("status not initialised");
    mreset_take_a: assert property (mreset_req |-> exc_take)
        else $error("reset request without entry");
    entry_bits_a: assert property (exc_take |->
        status_out[30:28] == 3'h7)
        else $error("block, mode or bank bit clear on entry");
    fetch_miss_a: assert property (f_gen && !blk |=> exc_take &&
        !mreset_req && exc_target[11:0] == 12'h400)
        else $error("fetch miss vector wrong");
    word_odd_a: assert property (o_odd && gen_ok |=> exc_take &&
        !mreset_req && exc_target[11:0] == 12'h100)
        else $error("odd word access not faulted");
    quad_align_a: assert property (o_quad && gen_ok |=> exc_take)
        else $error("misaligned quad access not faulted");
    user_upper_a: assert property (o_hi && gen_ok |=> exc_take)
        else $error("user access to upper half not faulted");
    blocked_reset_a: assert property (f_gen && blk |=>
        mreset_req && exc_target == `MAXU_RESET_PC)
        else $error("blocked fault did not take reset path");
    take_cause_a: assert property (exc_take |-> $past(fv || ov))
        else $error("entry without an instruction");
endmodule : maxu_assertions
bind maxu_core maxu_assertions i_chk (.pclk, .presetn, .fetch_in,
    .opnd_in, .exc_take, .exc_target, .mreset_req, .status_out);
`default_nettype wire

// ### bench/maxu_pipe_model.sv
// Pipeline and lookup model: one instruction per request pulse.
// Assumes go is a one-cycle pulse driven on pclk.
`timescale 1ns/100ps
`default_nettype none
module maxu_pipe_model
    import maxu_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Requests
    input wire logic go,
    input wire maxu_fetch_t f_req,
    input wire maxu_opnd_t o_req,
    input wire maxu_ctx_t c_req,
    // Towards the unit
    output var maxu_fetch_t fetch_in,
    output var maxu_opnd_t opnd_in,
    output var maxu_ctx_t ctx_in
);
    // Idle payload toggles so a stale address can never look valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_in <= '0;
            opnd_in <= '0;
            ctx_in <= '0;
        end else if (go) begin
            fetch_in <= f_req;
            opnd_in <= o_req;
            ctx_in <= c_req;
        end else begin
            fetch_in <= {1'b0, ~fetch_in[34:0]};
            opnd_in <= {1'b0, ~opnd_in[39:0]};
            ctx_in <= ~ctx_in;
        end
    end
endmodule : maxu_pipe_model
`default_nettype wire

// ### bench/maxu_core_test.sv
// Self-checking bench for maxu_core over APB and the pipeline model.
// Assumes maxu_pkg and maxu_consts.svh compiled ahead.
`timescale 1ns/100ps
`default_nettype none
`include "maxu_consts.svh"
module maxu_core_test
    import maxu_pkg::*;
;
    localparam logic [31:0] VB = 32'h12340000;
    localparam logic [31:0] PC = 32'h0c001230;
    localparam logic [31:0] R15 = 32'h7ffffff0;
    localparam logic [31:0] A = 32'h00401238;
    localparam logic [31:0] P = 32'h400000f0;
    localparam logic [31:0] U = 32'h000000f0;
    localparam logic [31:0] H = 32'h80000010;
    localparam maxu_size_t B = MAXU_SZ_BYTE;
    localparam maxu_size_t W = MAXU_SZ_WORD;
    localparam maxu_size_t L = MAXU_SZ_LONG;
    localparam maxu_size_t Q = MAXU_SZ_QUAD;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic slv;
    maxu_fetch_t f_req = '0;
    maxu_opnd_t o_req = '0;
    maxu_ctx_t c_req = '0;
    wire maxu_fetch_t fetch_in;
    wire maxu_opnd_t opnd_in;
    wire maxu_ctx_t ctx_in;
    wire logic [31:0] prdata, exc_target, status_out;
    wire logic pready, pslverr, exc_take, mreset_req;
    int errors = 0, samples_checked = 0;
    always #5 pclk = ~pclk;
    maxu_core i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .fetch_in, .opnd_in, .ctx_in,
        .exc_take, .exc_target, .mreset_req, .status_out);
    maxu_pipe_model i_pipe (.pclk, .presetn, .go, .f_req, .o_req, .c_req,
        .fetch_in, .opnd_in, .ctx_in);

    task test_done;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            errors++;
            test_done();
        end
        rd = prdata;
        slv = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask : apb

    task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk(n, e, rd);
    endtask : rdc

    // Code 12'hfff means no entry is expected; ofs 0 means reset path
    task fault(input logic [31:0] st, input logic fm, fmi, fp, ov, ow,
        input maxu_size_t sz, input logic om, omi, od, input logic [1:0] op,
        input logic [31:0] a, input logic [11:0] code, input logic [11:0] ofs);
        logic seen;
        logic rst;
        logic [31:0] tgt;
        rst = (ofs == 0);
        tgt = rst ? `MAXU_RESET_PC : VB + ofs;
        seen = 0;
        apb(1, `MAXU_OFS_STAT, st);
        apb(1, `MAXU_OFS_VBASE, VB);
        apb(1, `MAXU_OFS_SAVPC, 32'h5a5a5a5a);
        apb(1, `MAXU_OFS_PAGE, 32'h000000a5);
        f_req <= '{1'b1, a, fm, fmi, fp};
        o_req <= '{ov, a, ow, sz, om, omi, od, op};
        c_req <= '{PC, R15};
        go <= 1;
        @(posedge pclk);
        go <= 0;
        // Entry outputs launch on a rising edge; look at them mid-cycle
        for (int i = 0; i < 8 && !seen; i++) begin
            @(negedge pclk);
            seen = (exc_take === 1'b1);
        end
        chk("taken", {31'h0, code != 12'hfff}, {31'h0, seen});
        if (seen) begin
            chk("target", tgt, exc_target);
            chk("mreset", {31'h0, rst}, {31'h0, mreset_req});
        end
        @(posedge pclk);
        if (!seen) return;
        rdc("code", `MAXU_OFS_CODE, {20'h0, code});
        rdc("fault_address", `MAXU_OFS_FAULT, a);
        rdc("page", `MAXU_OFS_PAGE, {a[31:10], 10'h0a5});
        apb(0, `MAXU_OFS_STAT, 0);
        chk("status", 32'h7, {29'h0, rd[30:28]});
        if (rst) begin
            chk("init", 32'h0f, {27'h0, rd[15], rd[7:4]});
            rdc("vbase", `MAXU_OFS_VBASE, 0);
            rdc("saved_pc", `MAXU_OFS_SAVPC, 32'h5a5a5a5a);
        end else begin
            rdc("saved_pc", `MAXU_OFS_SAVPC, PC);
            rdc("saved_status", `MAXU_OFS_SSTAT, st);
            rdc("saved_stack", `MAXU_OFS_SSTK, R15);
        end
    endtask : fault

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        chk("status_out", `MAXU_ST_RST, status_out);
        apb(0, 8'h40, 0);
        chk("pslverr", 1, {31'h0, slv});
        chk("unmapped", 0, rd);
        fault(P, 1,0,1, 0,0,B, 0,0,1,2'h3, A, 12'h140, 0);
        fault(P, 0,0,1, 1,0,B, 1,0,1,2'h3, A, 12'h140, 0);
        fault(P, 0,1,1, 0,0,B, 0,0,1,2'h3, A, 12'h040, 12'h400);
        fault(P, 0,0,1, 1,0,L, 0,1,1,2'h3, A, 12'h040, 12'h400);
        fault(P, 0,0,1, 1,1,L, 0,1,1,2'h3, A, 12'h060, 12'h400);
        fault(P, 0,0,1, 1,1,L, 0,0,0,2'h3, A, 12'h080, 12'h100);
        fault(U, 0,0,1, 1,0,B, 0,0,1,2'h0, A, 12'h0a0, 12'h100);
        fault(U, 0,0,1, 1,1,B, 0,0,1,2'h1, A, 12'h0c0, 12'h100);
        fault(U, 0,0,1, 1,1,B, 0,0,1,2'h2, A, 12'h0c0, 12'h100);
        fault(P, 0,0,1, 1,1,B, 0,0,1,2'h0, A, 12'h0c0, 12'h100);
        fault(P, 0,0,1, 1,0,B, 0,0,1,2'h2, A, 12'hfff, 12'h100);
        fault(U, 0,0,1, 1,1,B, 0,0,1,2'h3, A, 12'hfff, 12'h100);
        fault(U, 0,0,0, 0,0,B, 0,0,1,2'h3, A, 12'h0a0, 12'h100);
        fault(P, 0,0,1, 1,0,W, 0,0,1,2'h3, A+1, 12'h0e0, 12'h100);
        fault(P, 0,0,1, 1,1,L, 0,0,1,2'h3, A+2, 12'h100, 12'h100);
        fault(P, 0,0,1, 1,0,Q, 0,0,1,2'h3, A+4, 12'h0e0, 12'h100);
        fault(U, 0,0,1, 1,1,B, 0,0,1,2'h3, H, 12'h100, 12'h100);
        fault(P, 0,0,1, 1,0,Q, 0,0,1,2'h3, A, 12'hfff, 12'h100);
        fault(32'h500000f0, 0,1,1, 0,0,B, 0,0,1,2'h3, A, 12'h020, 0);
        test_done();
    end
endmodule : maxu_core_test
`default_nettype wire
